// *** hw/assd_pkg.sv ***
// package: register map, field layout and framing constants of the serial block
package assd_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00; // serial_status_flags
  localparam logic [7:0] ADDR_DATA = 8'h04; // serial_data_port
  localparam logic [7:0] ADDR_CTRL = 8'h08; // serial_control_one

  // ---------------------------------------------------------------
  // status bit positions
  // ---------------------------------------------------------------
  localparam int ST_PF = 0; // parity_error_flag
  localparam int ST_FE = 1; // framing_error_flag
  localparam int ST_NF = 2; // noise_flag
  localparam int ST_OR = 3; // overrun flag
  localparam int ST_IDLE = 4; // idle-line flag
  localparam int ST_RAF = 5; // receiver_active_flag
  localparam int ST_RECEIVE_FULL_FLAG = 6; // receive_full_flag
  localparam int ST_TC = 7; // transmit_complete_flag
  localparam int ST_TRANSMIT_EMPTY_FLAG = 8; // transmit_empty_flag
  localparam int ST_W = 9; // status width
  localparam logic [8:0] ST_RST = 9'h180; // both transmit flags set
  localparam logic [8:0] RX_ACK = 9'h05f; // cleared by status read + data read
  localparam logic [8:0] TX_ACK = 9'h180; // cleared by status read + data write

  // ---------------------------------------------------------------
  // control bit positions
  // ---------------------------------------------------------------
  localparam int CT_DIV_W = 16; // bits [15:0] clocks per 1/16 bit
  localparam int CT_TE = 16; // transmitter enable
  localparam int CT_RE = 17; // receiver enable
  localparam int CT_RWU = 18; // receiver_wakeup_bit
  localparam int CT_ILT = 19; // idle_detect_type
  localparam int CT_PE = 20; // parity enable
  localparam int CT_PT = 21; // parity type, 1 = odd
  localparam int CT_M = 22; // nine data bits
  localparam int CT_SBK = 23; // send break
  localparam int CT_WAKE = 24; // wake on address mark
  localparam logic [31:0] CT_RST = 32'h0000_0000; // control reset value

  // ---------------------------------------------------------------
  // framing and oversampling
  // ---------------------------------------------------------------
  localparam logic [3:0] SMP_A = 4'h7; // first majority sample
  localparam logic [3:0] SMP_B = 4'h8; // second majority sample
  localparam logic [3:0] SMP_C = 4'h9; // third majority sample
  localparam logic [3:0] SUB_LAST = 4'hf; // last of 16 sub-ticks
  localparam logic [3:0] NB8 = 4'h8; // data bits, short frame
  localparam logic [3:0] NB9 = 4'h9; // data bits, long frame
  localparam logic [7:0] IDLE_T8 = 8'ha0; // 10 bit times of ticks
  localparam logic [7:0] IDLE_T9 = 8'hb0; // 11 bit times of ticks
  localparam logic [1:0] RESP_OK = 2'h0; // axi okay
  localparam logic [1:0] RESP_ERR = 2'h2; // axi slverr

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_FRAME = 2'b10} assd_rx_e;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} assd_tx_e;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } assd_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } assd_axi_rsp_s;

endpackage

// *** hw/assd_uart.sv ***
// serial status flags, data port, shifters and axi4-lite slave
`timescale 1ns/1ps

module assd_uart (
  input wire logic clk, // system clock
  input wire logic rst_b, // asynchronous reset, active low
  input wire assd_pkg::assd_axi_req_s axi_req, // axi4-lite requests
  output assd_pkg::assd_axi_rsp_s axi_rsp, // axi4-lite answers
  input wire logic rxd, // serial receive line
  output logic txd // serial transmit line
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [8:0] st_r, st_nxt, st_set, st_clr, arm_r;
  logic [31:0] ctrl_r, ctrl_wr;
  logic [8:0] tdr_r, rdr_r;
  logic bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic rxd_m_r, rxd_s;
  logic [15:0] baud_cnt_r;
  assd_pkg::assd_rx_e rx_st_r;
  assd_pkg::assd_tx_e tx_st_r;
  logic [3:0] rx_sub_r, rx_bit_r, tx_sub_r, tx_bit_r;
  logic [2:0] rx_smp_r;
  logic [8:0] rx_sh_r;
  logic [10:0] tx_sh_r;
  logic rx_nz_r, idle_arm_r, txd_r;
  logic [7:0] idle_cnt_r;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire wr_go = axi_req.awvalid && axi_req.wvalid && !bvalid_r;
  wire rd_go = axi_req.arvalid && !rvalid_r;
  wire wr_ok = axi_req.awaddr == assd_pkg::ADDR_DATA || axi_req.awaddr == assd_pkg::ADDR_CTRL;
  wire rd_st = axi_req.araddr == assd_pkg::ADDR_STATUS;
  wire rd_dt = axi_req.araddr == assd_pkg::ADDR_DATA;
  wire rd_ct = axi_req.araddr == assd_pkg::ADDR_CTRL;
  wire srd = rd_go && rd_st;
  wire drd = rd_go && rd_dt; // shared address, read side
  wire dwr = wr_go && axi_req.awaddr == assd_pkg::ADDR_DATA; // write side
  wire cwr = wr_go && axi_req.awaddr == assd_pkg::ADDR_CTRL;

  // control fields
  wire [15:0] div = ctrl_r[assd_pkg::CT_DIV_W-1:0];
  wire te = ctrl_r[assd_pkg::CT_TE];
  wire re = ctrl_r[assd_pkg::CT_RE];
  wire receiver_wakeup_bit = ctrl_r[assd_pkg::CT_RWU];
  wire idle_detect_type = ctrl_r[assd_pkg::CT_ILT];
  wire pe = ctrl_r[assd_pkg::CT_PE];
  wire pt = ctrl_r[assd_pkg::CT_PT];
  wire m9 = ctrl_r[assd_pkg::CT_M];
  wire sbk = ctrl_r[assd_pkg::CT_SBK];
  wire wake = ctrl_r[assd_pkg::CT_WAKE];
  wire [3:0] nbits = m9 ? assd_pkg::NB9 : assd_pkg::NB8;
  wire [3:0] last_bit = nbits + 4'h1;

  // ---------------------------------------------------------------
  // axi answer channels
  // ---------------------------------------------------------------
  assign axi_rsp.awready = wr_go;
  assign axi_rsp.wready = wr_go;
  assign axi_rsp.bvalid = bvalid_r;
  assign axi_rsp.bresp = bresp_r;
  assign axi_rsp.arready = rd_go;
  assign axi_rsp.rvalid = rvalid_r;
  assign axi_rsp.rdata = rdata_r;
  assign axi_rsp.rresp = rresp_r;
  assign txd = txd_r;

  // write response
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_r <= 1'b0;
      bresp_r <= assd_pkg::RESP_OK;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? assd_pkg::RESP_OK : assd_pkg::RESP_ERR;
    end else if (axi_req.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read data, status view in low bits
  wire [31:0] rd_mux = rd_st ? {23'h0, st_r} : rd_dt ? {23'h0, rdr_r} : rd_ct ? ctrl_r : 32'h0;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= assd_pkg::RESP_OK;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= (rd_st || rd_dt || rd_ct) ? assd_pkg::RESP_OK : assd_pkg::RESP_ERR;
    end else if (axi_req.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control and transmit holding registers
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_wr = ctrl_r;
    for (int i = 0; i < 4; i++) begin
      if (axi_req.wstrb[i]) begin
        ctrl_wr[8*i +: 8] = axi_req.wdata[8*i +: 8];
      end
    end
  end

  // wakeup clears the wakeup bit unless software writes it
  wire wake_idle, woke_addr;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= assd_pkg::CT_RST;
      tdr_r <= 9'h0;
    end else begin
      if (cwr) ctrl_r <= ctrl_wr;
      else if (wake_idle || woke_addr) ctrl_r[assd_pkg::CT_RWU] <= 1'b0;
      if (dwr) tdr_r <= axi_req.wdata[8:0];
    end
  end

  // ---------------------------------------------------------------
  // line synchroniser and 16x baud tick
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxd_m_r <= 1'b1;
      rxd_s <= 1'b1;
    end else begin
      rxd_m_r <= rxd;
      rxd_s <= rxd_m_r;
    end
  end

  wire tick = div != 16'h0 && baud_cnt_r >= div - 16'h1;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) baud_cnt_r <= 16'h0;
    else baud_cnt_r <= tick || div == 16'h0 ? 16'h0 : baud_cnt_r + 16'h1;
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  wire [2:0] s = rx_smp_r;
  wire maj = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  wire dis = |s && !(&s); // any disagreement
  wire bit_end = tick && rx_st_r == assd_pkg::RX_FRAME && rx_sub_r == assd_pkg::SUB_LAST;
  wire start_rej = bit_end && rx_bit_r == 4'h0 && maj; // false start, noise dropped
  wire rx_done = bit_end && rx_bit_r == last_bit;
  wire stop_zero = !maj; // a one by chance hides the error
  wire frame_nz = rx_nz_r | dis;
  wire [8:0] rx_data = m9 ? rx_sh_r : {1'b0, rx_sh_r[7:0]};
  wire addr_mark = m9 ? rx_sh_r[8] : rx_sh_r[7];
  assign woke_addr = rx_done && receiver_wakeup_bit && wake && addr_mark;
  wire accept = rx_done && (!receiver_wakeup_bit || woke_addr);
  wire rx_load = accept && !st_r[assd_pkg::ST_RECEIVE_FULL_FLAG] && !st_r[assd_pkg::ST_OR];
  wire or_set = accept && st_r[assd_pkg::ST_RECEIVE_FULL_FLAG];
  wire par_err = pe && ((^rx_data) != pt);
  wire start_det = tick && re && rx_st_r == assd_pkg::RX_IDLE && !rxd_s;

  // frame sampler, three samples around mid-bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_r <= assd_pkg::RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_smp_r <= 3'h7;
      rx_sh_r <= 9'h0;
      rx_nz_r <= 1'b0;
    end else if (tick) begin
      case (rx_st_r)
        assd_pkg::RX_IDLE: begin
          if (re && !rxd_s) begin
            rx_st_r <= assd_pkg::RX_FRAME;
            rx_sub_r <= 4'h0;
            rx_bit_r <= 4'h0;
            rx_nz_r <= 1'b0;
          end
        end
        assd_pkg::RX_FRAME: begin
          rx_sub_r <= rx_sub_r + 4'h1;
          if (rx_sub_r == assd_pkg::SMP_A || rx_sub_r == assd_pkg::SMP_B ||
              rx_sub_r == assd_pkg::SMP_C) begin
            rx_smp_r <= {rx_smp_r[1:0], rxd_s};
          end
          if (rx_sub_r == assd_pkg::SUB_LAST) begin
            rx_bit_r <= rx_bit_r + 4'h1;
            rx_nz_r <= frame_nz;
            if (rx_bit_r != 4'h0 && rx_bit_r <= nbits) rx_sh_r[rx_bit_r - 4'h1] <= maj;
            if (start_rej || rx_done) rx_st_r <= assd_pkg::RX_IDLE;
          end
        end
        default: rx_st_r <= assd_pkg::RX_IDLE;
      endcase
    end
  end

  // held word and idle re-arm
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdr_r <= 9'h0;
      idle_arm_r <= 1'b1;
    end else begin
      if (rx_load) rdr_r <= rx_data; // overrun keeps the old word
      if (rx_load) idle_arm_r <= 1'b1;
      else if (st_set[assd_pkg::ST_IDLE]) idle_arm_r <= 1'b0;
    end
  end

  // idle counter: long type holds it through the frame
  wire hold = !rxd_s || !re || (idle_detect_type && rx_st_r == assd_pkg::RX_FRAME);
  wire [7:0] idle_thr = m9 ? assd_pkg::IDLE_T9 : assd_pkg::IDLE_T8;
  wire idle_ev = tick && !hold && idle_cnt_r == idle_thr - 8'h1;
  assign wake_idle = idle_ev && receiver_wakeup_bit && !wake;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) idle_cnt_r <= 8'h0;
    else if (hold) idle_cnt_r <= 8'h0;
    else if (tick && idle_cnt_r != idle_thr) idle_cnt_r <= idle_cnt_r + 8'h1;
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  wire tx_d8 = m9 ? (pe ? (^tdr_r[7:0]) ^ pt : tdr_r[8]) : 1'b1;
  wire tx_d7 = (!m9 && pe) ? (^tdr_r[6:0]) ^ pt : tdr_r[7];
  wire [10:0] tx_frame = {1'b1, tx_d8, tx_d7, tdr_r[6:0], 1'b0};
  wire tx_load = tick && tx_st_r == assd_pkg::TX_IDLE && te && (sbk || !st_r[assd_pkg::ST_TRANSMIT_EMPTY_FLAG]);
  wire tx_end = tick && tx_st_r == assd_pkg::TX_SHIFT && tx_sub_r == assd_pkg::SUB_LAST &&
                tx_bit_r == last_bit;

  // shifter, break frames are all zeros
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_r <= assd_pkg::TX_IDLE;
      tx_sub_r <= 4'h0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 11'h7ff;
    end else if (tick) begin
      case (tx_st_r)
        assd_pkg::TX_IDLE: begin
          if (tx_load) begin
            tx_st_r <= assd_pkg::TX_SHIFT;
            tx_sh_r <= sbk ? 11'h000 : tx_frame;
            tx_sub_r <= 4'h0;
            tx_bit_r <= 4'h0;
          end
        end
        assd_pkg::TX_SHIFT: begin
          tx_sub_r <= tx_sub_r + 4'h1;
          if (tx_sub_r == assd_pkg::SUB_LAST) begin
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_end) tx_st_r <= assd_pkg::TX_IDLE;
          end
        end
        default: tx_st_r <= assd_pkg::TX_IDLE;
      endcase
    end
  end

  // line idles high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) txd_r <= 1'b1;
    else txd_r <= tx_st_r != assd_pkg::TX_SHIFT || tx_sh_r[0];
  end

  // ---------------------------------------------------------------
  // status flags: set wins over clear
  // ---------------------------------------------------------------
  always_comb begin
    st_set = 9'h0;
    st_set[assd_pkg::ST_TRANSMIT_EMPTY_FLAG] = tx_load && !sbk;
    st_set[assd_pkg::ST_TC] = tx_end && st_r[assd_pkg::ST_TRANSMIT_EMPTY_FLAG] && !sbk;
    st_set[assd_pkg::ST_RECEIVE_FULL_FLAG] = rx_load;
    st_set[assd_pkg::ST_NF] = rx_load && frame_nz;
    st_set[assd_pkg::ST_FE] = rx_load && stop_zero;
    st_set[assd_pkg::ST_PF] = rx_load && par_err;
    st_set[assd_pkg::ST_OR] = or_set;
    st_set[assd_pkg::ST_IDLE] = idle_ev && !receiver_wakeup_bit && idle_arm_r;
    st_set[assd_pkg::ST_RAF] = start_det && !receiver_wakeup_bit;
    st_clr = (drd ? arm_r & assd_pkg::RX_ACK : 9'h0) |
             (dwr ? arm_r & assd_pkg::TX_ACK : 9'h0);
    st_clr[assd_pkg::ST_TC] = st_clr[assd_pkg::ST_TC] | tx_load;
    st_clr[assd_pkg::ST_RAF] = idle_ev;
    st_nxt = (st_r & ~st_clr) | st_set;
  end

  // flags and the snapshot taken by a status read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= assd_pkg::ST_RST;
      arm_r <= 9'h0;
    end else begin
      st_r <= st_nxt;
      if (srd) arm_r <= st_r & (assd_pkg::RX_ACK | assd_pkg::TX_ACK);
      else arm_r <= arm_r & ~(drd ? assd_pkg::RX_ACK : 9'h0) & ~(dwr ? assd_pkg::TX_ACK : 9'h0);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_err_with_full: assert property (
    $rose(st_r[assd_pkg::ST_NF]) |-> $rose(st_r[assd_pkg::ST_RECEIVE_FULL_FLAG]))
    else $error("noise flag rose without receive full");
  a_overrun_keeps: assert property ($rose(st_r[assd_pkg::ST_OR]) |-> $stable(rdr_r))
    else $error("held word changed on overrun");
  a_raf_start: assert property (start_det && !receiver_wakeup_bit |=> st_r[assd_pkg::ST_RAF])
    else $error("active flag not set on start");
  a_tc_busy: assert property (tx_st_r == assd_pkg::TX_SHIFT |-> !st_r[assd_pkg::ST_TC])
    else $error("transmit complete while shifting");
  a_wakeup_quiet: assert property ($rose(st_r[assd_pkg::ST_RECEIVE_FULL_FLAG]) && !$past(wake)
                                   |-> !$past(receiver_wakeup_bit))
    else $error("receive full set in wakeup mode");
  a_idle_rearm: assert property ($rose(st_r[assd_pkg::ST_IDLE]) |-> $past(idle_arm_r))
    else $error("idle flag set without rearm");
  a_transmit_empty_flag_load: assert property (
    tx_load && !sbk |=> st_r[assd_pkg::ST_TRANSMIT_EMPTY_FLAG] && !tx_sh_r[0])
    else $error("load did not free holding register");
  a_fe_stop: assert property (rx_load |=> st_r[assd_pkg::ST_FE] == $past(stop_zero))
    else $error("framing flag does not match stop sample");

endmodule // assd_uart

// *** verif/assd_remote.sv ***
// remote serial station model facing the block's serial lines
`timescale 1ns/1ps
module assd_remote (
  input wire logic clk, // system clock, times the bits
  output logic line_o, // drives the block's receive line
  input wire logic line_i // watches the block's transmit line
);
  // ---------------------------------------------------------------
  // frame sender: start 0, data lsb first, stop, 16 clocks a bit
  // ---------------------------------------------------------------
  initial line_o = 1'b1;
  task automatic send(input logic [8:0] d, input int nb, input logic stp, input bit nz);
    logic v;
    for (int i = 0; i < nb + 2; i++) begin
      v = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : stp;
      for (int c = 0; c < 16; c++) begin
        @(posedge clk);
        line_o <= (nz && i == 3 && c == 10) ? ~v : v;
      end
    end
    @(posedge clk);
    line_o <= 1'b1;
  endtask

  // ---------------------------------------------------------------
  // frame catcher: samples mid-bit after the falling start edge
  // ---------------------------------------------------------------
  task automatic recv(input int nb, output logic [8:0] d, output logic stp);
    d = 9'h000;
    @(negedge line_i);
    repeat (8) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (16) @(posedge clk);
      d[i] = line_i;
    end
    repeat (16) @(posedge clk);
    stp = line_i;
  endtask

  // short low pulse the receiver must drop as a false start
  task automatic pulse(input int n);
    @(posedge clk);
    line_o <= 1'b0;
    repeat (n) @(posedge clk);
    line_o <= 1'b1;
  endtask
endmodule // assd_remote

// *** verif/testbench.sv ***
// self-checking bench: axi4-lite register tasks and serial traffic
`timescale 1ns/1ps
`define CHK(g, e) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); \
  end \
end
module testbench;
  localparam logic [7:0] AS = assd_pkg::ADDR_STATUS; // status flags
  localparam logic [7:0] AD = assd_pkg::ADDR_DATA; // data port
  localparam logic [7:0] AC = assd_pkg::ADDR_CTRL; // control
  localparam logic [31:0] TXC = 32'h0001_0001; // div 1, transmitter on
  localparam logic [31:0] RXC = 32'h0003_0001; // div 1, both sides on
  // error table: data, and {pt, pe, noise, bad stop, nf/fe/pf expected}
  localparam logic [8:0] T_D [7] = '{9'h055, 9'h000, 9'h03c, 9'h081, 9'h001, 9'h001, 9'h081};
  localparam logic [6:0] T_C [7] = '{7'h0a, 7'h0a, 7'h14, 7'h20, 7'h21, 7'h60, 7'h61};
  logic clk;
  logic rst_b;
  assd_pkg::assd_axi_req_s req;
  assd_pkg::assd_axi_rsp_s rsp;
  logic rxd;
  logic txd;
  logic [31:0] rd_d;
  logic [1:0] rd_r;
  logic [1:0] wr_r;
  logic [8:0] cap;
  logic cap_stp;
  int n_errors = 0;
  int n_checks = 0;

  assd_uart uut (.clk(clk), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp), .rxd(rxd), .txd(txd));
  assd_remote far (.clk(clk), .line_o(rxd), .line_i(txd));

  // 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do @(posedge clk); while (rsp.awready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    wr_r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    rd_d = rsp.rdata;
    rd_r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rd_d, e)
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog, about three times the expected run
  initial begin
    #80000;
    n_errors++;
    summarize();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    req = '0;
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    `CHK(txd, 1'b1)
    chk_rd(AS, 32'h0000_0180);
    chk_rd(AC, 32'h0000_0000);
    chk_rd(8'h0c, 32'h0000_0000);
    `CHK(rd_r, assd_pkg::RESP_ERR)
    wr(8'h0c, 32'h0000_0001);
    `CHK(wr_r, assd_pkg::RESP_ERR)
    $display("test reset_and_map done");
    // transmit both frame lengths; ninth bit ignored in short frames
    for (int m = 0; m < 2; m++) begin
      wr(AC, TXC | (32'(m) << 22));
      fork
        far.recv(8 + m, cap, cap_stp);
        begin
          chk_rd(AS, 32'h0000_0180);
          wr(AD, m ? 32'h0000_01a5 : 32'h0000_015a);
          repeat (40) @(posedge clk);
          chk_rd(AS, 32'h0000_0100);
        end
      join
      `CHK(cap, m ? 9'h1a5 : 9'h05a)
      `CHK(cap_stp, 1'b1)
      repeat (20) @(posedge clk);
    end
    chk_rd(AS, 32'h0000_0180);
    // break frames while send-break is set, then the transmitter idles
    wr(AC, TXC | 32'h0080_0000);
    far.recv(8, cap, cap_stp);
    wr(AC, TXC);
    `CHK({cap_stp, cap}, 10'h000)
    repeat (200) @(posedge clk);
    chk_rd(AS, 32'h0000_0180);
    $display("test transmit done");
    // receive, clear sequence, idle and active flags
    wr(AC, RXC);
    repeat (250) @(posedge clk);
    chk_rd(AS, 32'h0000_0190);
    rd(AD);
    chk_rd(AS, 32'h0000_0180);
    far.send(9'h0a3, 8, 1'b1, 1'b0);
    repeat (8) @(posedge clk);
    chk_rd(AD, 32'h0000_00a3);
    chk_rd(AS, 32'h0000_01e0);
    chk_rd(AD, 32'h0000_00a3);
    chk_rd(AS, 32'h0000_01a0);
    repeat (250) @(posedge clk);
    chk_rd(AS, 32'h0000_0190);
    rd(AD);
    far.pulse(4);
    repeat (250) @(posedge clk);
    chk_rd(AS, 32'h0000_0180);
    $display("test receive done");
    // overrun keeps the first word and drops the second
    far.send(9'h011, 8, 1'b1, 1'b0);
    far.send(9'h022, 8, 1'b1, 1'b0);
    repeat (8) @(posedge clk);
    chk_rd(AS, 32'h0000_01e8);
    chk_rd(AD, 32'h0000_0011);
    chk_rd(AS, 32'h0000_01a0);
    far.send(9'h033, 8, 1'b1, 1'b0);
    repeat (8) @(posedge clk);
    chk_rd(AS, 32'h0000_01e0);
    chk_rd(AD, 32'h0000_0033);
    $display("test overrun done");
    // framing, break, noise, even and odd parity
    for (int i = 0; i < 7; i++) begin
      wr(AC, RXC | (32'(T_C[i][6:5]) << 20));
      far.send(T_D[i], 8, ~T_C[i][3], T_C[i][4]);
      repeat (8) @(posedge clk);
      chk_rd(AS, 32'h0000_01e0 | 32'(T_C[i][2:0]));
      chk_rd(AD, 32'(T_D[i]));
    end
    $display("test errors done");
    // wakeup ignores plain words until an address mark arrives
    wr(AC, RXC | 32'h0104_0000);
    far.send(9'h044, 8, 1'b1, 1'b0);
    repeat (8) @(posedge clk);
    rd(AS);
    `CHK(rd_d & 32'h0000_01df, 32'h0000_0180)
    far.send(9'h0c4, 8, 1'b1, 1'b0);
    repeat (8) @(posedge clk);
    rd(AS);
    `CHK(rd_d & 32'h0000_01df, 32'h0000_01c0)
    chk_rd(AD, 32'h0000_00c4);
    chk_rd(AC, RXC | 32'h0100_0000);
    // nine data bits land in the top bit of the data port
    wr(AC, RXC | 32'h0040_0000);
    far.send(9'h1a5, 9, 1'b1, 1'b0);
    repeat (8) @(posedge clk);
    chk_rd(AS, 32'h0000_01e0);
    chk_rd(AD, 32'h0000_01a5);
    $display("test wakeup_and_long done");
    // short idle counts from the first one, long from after the stop bit
    for (int l = 0; l < 2; l++) begin
      wr(AC, RXC | (32'(l) << 19));
      far.send(9'h0ff, 8, 1'b1, 1'b0);
      repeat (40) @(posedge clk);
      chk_rd(AS, l ? 32'h0000_01e0 : 32'h0000_01d0);
      rd(AD);
      repeat (200) @(posedge clk);
      chk_rd(AS, l ? 32'h0000_0190 : 32'h0000_0180);
    end
    // idle line wakes a receiver waiting in wakeup mode
    wr(AC, RXC | 32'h0004_0000);
    far.send(9'h0ff, 8, 1'b1, 1'b0);
    repeat (40) @(posedge clk);
    chk_rd(AS, 32'h0000_0190);
    chk_rd(AC, RXC);
    $display("test idle_type done");
    summarize();
  end
endmodule // testbench
